// [inc/mps_regs.svh]
// register offsets, field positions, reset values and timing for the motion program sequencer
`ifndef MPS_REGS_SVH
`define MPS_REGS_SVH
// ==========================================
// sizes
`define MPS_NSLOT     63
`define MPS_NPAR      4
`define MPS_NDLY      16
`define MPS_PW        20
// ==========================================
// apb byte offsets
`define MPS_A_CTRL    12'h000
`define MPS_A_STAT    12'h004
`define MPS_A_PVAL    12'h040
`define MPS_A_PATR    12'h060
`define MPS_A_DLY     12'h080
`define MPS_A_PROG    12'h100
// ==========================================
// program word fields
`define MPS_F_TYPE    2:0
`define MPS_F_INS     4
`define MPS_F_OVERLAP_LINK_FLAG    5
`define MPS_F_AUTO    6
`define MPS_F_DLY     11:8
`define MPS_F_JMP     17:12
// parameter attribute bits
`define MPS_AT_VOL    0
`define MPS_AT_RST    1
`define MPS_AT_LCK    2
// control bits and reset values
`define MPS_CTRL_SON  0
`define MPS_SON_RST   1'b1
// ==========================================
// timing: delay tick of 1 ms at a 4 ns clock
`define MPS_TICK_NS   1000000
`define MPS_CLK_NS    4
`endif

// [inc/mps_pkg.sv]
// types of the motion program sequencer
`include "mps_regs.svh"
package mps_pkg;
   typedef enum logic [1:0] {MPS_IDLE, MPS_RUN, MPS_WAIT} mps_state_e;
   typedef enum logic [2:0] {MPS_SPEED, MPS_POS, MPS_JUMP, MPS_PWRITE, MPS_INDEX} mps_ctype_e;
   typedef struct packed {
      logic       start;
      logic       abort;
      logic       overlap;
      logic [5:0] slot;
   } mps_cmd_s;
   typedef struct packed {
      mps_state_e                                 fsm;
      logic [5:0]                                 cur;
      logic [5:0]                                 pend;
      logic                                       pend_v;
      logic                                       fresh;
      logic                                       done_seen;
      logic                                       seq_ins;
      logic [15:0]                                dly_cnt;
      logic [19:0]                                tick_cnt;
      logic [`MPS_NSLOT:0][`MPS_PW-1:0]           prog;
      logic [`MPS_NDLY-1:0][15:0]                 dly;
      logic [`MPS_NPAR-1:0][31:0]                 par_st;
      logic [`MPS_NPAR-1:0][31:0]                 par_ap;
      logic [`MPS_NPAR-1:0][2:0]                  attr;
      logic                                       ctrl_son;
      logic                                       servo_on_input;
      logic                                       rej;
      logic                                       active;
      logic                                       pready;
      logic                                       pslverr;
      logic [31:0]                                prdata;
      mps_cmd_s                                   cmd;
   } mps_st_s;
endpackage

// [rtl/mps_top.sv]
// motion program sequencer with apb register file and parameter store
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "mps_regs.svh"
module mps_top #(
   parameter int TICK_CYC = (`MPS_TICK_NS + `MPS_CLK_NS - 1) / `MPS_CLK_NS
) (
   input  wire logic            i_clk,
   input  wire logic            i_sys_rst,
   input  wire logic            i_psel,
   input  wire logic            i_penable,
   input  wire logic            i_pwrite,
   input  wire logic [11:0]     i_paddr,
   input  wire logic [31:0]     i_pwdata,
   output logic [31:0]          o_prdata,
   output logic                 o_pready,
   output logic                 o_pslverr,
   input  wire logic [5:0]      i_discrete_input,
   input  wire logic            i_trigger,
   input  wire logic            i_servo_on_input,
   input  wire logic            i_power_cycle,
   input  wire logic            i_mot_done,
   input  wire logic            i_mot_decel,
   output mps_pkg::mps_cmd_s    o_cmd,
   output logic                 o_active,
   output logic                 o_servo_on
);
   localparam logic [19:0] TK     = 20'(TICK_CYC - 1);
   localparam logic [11:0] A_PVAL = `MPS_A_PVAL;
   localparam logic [11:0] A_PATR = `MPS_A_PATR;
   localparam logic [11:0] A_DLY  = `MPS_A_DLY;
   localparam logic [11:0] A_PROG = `MPS_A_PROG;

   mps_pkg::mps_st_s     r;
   mps_pkg::mps_st_s     n;
   logic [`MPS_PW-1:0]   cw;
   logic [`MPS_PW-1:0]   nw;
   logic [`MPS_PW-1:0]   tw;
   logic [5:0]           nx;
   logic                 nx_ok;
   logic                 sq;
   logic                 trg;

   // ==========================================
   // sequencing helpers
   assign cw    = r.prog[r.cur];
   assign nx    = (cw[`MPS_F_TYPE] == mps_pkg::MPS_JUMP) ? cw[`MPS_F_JMP] :
                  ((r.cur == 6'h3f) ? 6'h00 : r.cur + 6'h01);
   assign nw    = r.prog[nx];
   assign nx_ok = cw[`MPS_F_AUTO] && (nx != 6'h00);
   assign tw    = r.prog[i_discrete_input];
   assign trg   = i_trigger && (i_discrete_input != 6'h00);
   // flag of the following program decides the link kind
   assign sq    = r.fresh ? (nx_ok && nw[`MPS_F_INS]) : r.seq_ins;

   // ==========================================
   // next state
   always_comb
   begin
      logic        go;
      logic        ab;
      logic        ov;
      logic [5:0]  gs;
      logic [31:0] rd;
      logic        hit;
      logic        acc;
      logic        wr;
      logic        tk;
      go  = 1'b0;
      tk  = 1'b0;
      acc = 1'b0;
      wr  = 1'b0;
      ab  = 1'b0;
      ov  = 1'b0;
      gs  = 6'h00;
      rd  = 32'h0;
      hit = 1'b1;
      n   = r;
      n.cmd.start   = 1'b0;
      n.cmd.abort   = 1'b0;
      n.cmd.overlap = 1'b0;
      // delay prescaler wraps every tick and restarts when a delay loads, whole ticks only
      if (r.tick_cnt == TK)
      begin
         n.tick_cnt = 20'h0;
         if (r.dly_cnt != 16'h0)
            n.dly_cnt = r.dly_cnt - 16'h1;
      end
      else
         n.tick_cnt = r.tick_cnt + 20'h1;
      // external trigger: interrupt replaces, else start only if nothing runs
      if (trg && (tw[`MPS_F_INS] || r.fsm != mps_pkg::MPS_RUN || r.done_seen))
      begin
         go = 1'b1;
         tk = 1'b1;
         gs = i_discrete_input;
         ab = (r.fsm == mps_pkg::MPS_RUN) && !r.done_seen;
         n.pend_v = 1'b0;
      end
      if (!go)
      begin
         unique case (r.fsm)
            mps_pkg::MPS_IDLE: ;
            mps_pkg::MPS_RUN:
            begin
               if (r.fresh)
               begin
                  // arm from program start for an internal interrupt link
                  n.fresh   = 1'b0;
                  n.seq_ins = sq;
                  n.dly_cnt = r.dly[cw[`MPS_F_DLY]];
                  n.tick_cnt = 20'h0;
               end
               if (!r.fresh && r.seq_ins && r.dly_cnt == 16'h0)
               begin
                  go = 1'b1;
                  gs = nx;
                  ab = !r.done_seen;
               end
               else if (i_mot_decel && !r.done_seen && nx_ok && cw[`MPS_F_OVERLAP_LINK_FLAG] &&
                        cw[`MPS_F_TYPE] == mps_pkg::MPS_POS && nw[`MPS_F_TYPE] == mps_pkg::MPS_POS)
               begin
                  go = 1'b1;
                  gs = nx;
                  ov = 1'b1;
               end
               else if (i_mot_done && !r.done_seen)
               begin
                  n.done_seen = 1'b1;
                  if (r.pend_v)
                  begin
                     go = 1'b1;
                     gs = r.pend;
                     n.pend_v = 1'b0;
                  end
                  else if (!sq)
                  begin
                     // sequential delay counts from target reached
                     n.fsm      = nx_ok ? mps_pkg::MPS_WAIT : mps_pkg::MPS_IDLE;
                     n.dly_cnt  = r.dly[cw[`MPS_F_DLY]];
                     n.tick_cnt = 20'h0;
                  end
               end
            end
            mps_pkg::MPS_WAIT:
               if (r.dly_cnt == 16'h0)
               begin
                  go = 1'b1;
                  gs = nx;
               end
         endcase
      end
      // trigger not taken now stays pending, newest wins; an internal launch
      // in the same cycle must not swallow it
      if (trg && !tk)
      begin
         n.pend_v = 1'b1;
         n.pend   = i_discrete_input;
      end
      // launch: exactly one program owns the motion
      if (go)
      begin
         n.fsm         = mps_pkg::MPS_RUN;
         n.cur         = gs;
         n.fresh       = 1'b1;
         n.done_seen   = 1'b0;
         n.seq_ins     = 1'b0;
         n.cmd.start   = 1'b1;
         n.cmd.abort   = ab;
         n.cmd.overlap = ov;
         n.cmd.slot    = gs;
      end
      // apb: one wait state, data and error from flops
      acc = i_psel && i_penable && !r.pready;
      wr  = i_psel && i_penable && r.pready && i_pwrite && !r.pslverr;
      if (i_paddr == `MPS_A_CTRL)
         rd = {31'h0, r.ctrl_son};
      else if (i_paddr == `MPS_A_STAT)
         rd = {r.rej, 1'b0, r.pend, 7'h0, r.pend_v, 2'h0, r.cur, 7'h0, r.active};
      else if (i_paddr[11:4] == A_PVAL[11:4] && i_paddr[1:0] == 2'h0)
         rd = r.par_ap[i_paddr[3:2]];
      else if (i_paddr[11:4] == A_PATR[11:4] && i_paddr[1:0] == 2'h0)
         rd = {29'h0, r.attr[i_paddr[3:2]]};
      else if (i_paddr[11:6] == A_DLY[11:6] && i_paddr[1:0] == 2'h0)
         rd = {16'h0, r.dly[i_paddr[5:2]]};
      else if (i_paddr[11:8] == A_PROG[11:8] && i_paddr[1:0] == 2'h0)
         rd = {12'h0, r.prog[i_paddr[7:2]]};
      else
         hit = 1'b0;
      n.pready  = acc;
      n.pslverr = acc && !hit;
      n.prdata  = acc ? rd : 32'h0;
      if (wr)
      begin
         if (i_paddr == `MPS_A_CTRL)
            n.ctrl_son = i_pwdata[`MPS_CTRL_SON];
         if (i_paddr == `MPS_A_STAT)
            n.rej = 1'b0;
         if (i_paddr[11:6] == A_DLY[11:6])
            n.dly[i_paddr[5:2]] = i_pwdata[15:0];
         // slot zero means no program and cannot be written
         if (i_paddr[11:8] == A_PROG[11:8] && i_paddr[7:2] != 6'h00)
            n.prog[i_paddr[7:2]] = i_pwdata[`MPS_PW-1:0];
      end
      // parameter store, per entry
      for (int i = 0; i < `MPS_NPAR; i++)
      begin
         if (wr && i_paddr[11:4] == A_PATR[11:4] && i_paddr[3:2] == 2'(i))
            n.attr[i] = i_pwdata[2:0];
         if (wr && i_paddr[11:4] == A_PVAL[11:4] && i_paddr[3:2] == 2'(i))
         begin
            if (r.attr[i][`MPS_AT_LCK] && r.servo_on_input)
               n.rej = 1'b1;
            else
            begin
               n.par_st[i] = i_pwdata;
               if (!r.attr[i][`MPS_AT_RST])
                  n.par_ap[i] = i_pwdata;
            end
         end
         if (i_power_cycle)
         begin
            if (r.attr[i][`MPS_AT_VOL])
            begin
               n.par_st[i] = 32'h0;
               n.par_ap[i] = 32'h0;
            end
            else
               n.par_ap[i] = r.par_st[i];
         end
      end
      // servo-on needs both the input and the software bit
      n.servo_on_input    = i_servo_on_input && n.ctrl_son;
      n.active = (n.fsm != mps_pkg::MPS_IDLE);
   end

   // ==========================================
   // state register
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         r          <= '0;
         r.fsm      <= mps_pkg::MPS_IDLE;
         r.ctrl_son <= `MPS_SON_RST;
      end
      else
         r <= n;
   end

   assign o_prdata   = r.prdata;
   assign o_pready   = r.pready;
   assign o_pslverr  = r.pslverr;
   assign o_cmd      = r.cmd;
   assign o_active   = r.active;
   assign o_servo_on = r.servo_on_input;

   // ==========================================
   // assertions
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);

   overlap_link_flag_blend_a: assert property (r.fsm == mps_pkg::MPS_RUN && !r.fresh && !r.done_seen && !trg && !r.seq_ins
      && i_mot_decel && nx_ok && cw[`MPS_F_OVERLAP_LINK_FLAG] && cw[`MPS_F_TYPE] == mps_pkg::MPS_POS
      && nw[`MPS_F_TYPE] == mps_pkg::MPS_POS |=> o_cmd.start && o_cmd.overlap && o_cmd.slot == $past(nx))
      else $error("overlap did not blend");
   overlap_link_flag_pos_only_a: assert property (o_cmd.overlap |-> $past(cw[`MPS_F_TYPE]) == mps_pkg::MPS_POS)
      else $error("overlap from non positioning");
   seq_wait_a: assert property (r.fsm == mps_pkg::MPS_RUN && !r.fresh && !r.seq_ins && !r.done_seen && i_mot_done
      && !r.pend_v && nx_ok && !trg && !i_mot_decel |=> r.fsm == mps_pkg::MPS_WAIT && !o_cmd.start)
      else $error("sequential delay not started on completion");
   wait_launch_a: assert property (r.fsm == mps_pkg::MPS_WAIT && r.dly_cnt == 16'h0 && !trg
      |=> o_cmd.start && !o_cmd.abort && o_cmd.slot == $past(nx))
      else $error("auto continuation missed");
   ins_abort_a: assert property (r.fsm == mps_pkg::MPS_RUN && !r.fresh && r.seq_ins && r.dly_cnt == 16'h0
      && !r.done_seen && !trg |=> o_cmd.start && o_cmd.abort)
      else $error("internal interrupt did not abort");
   ext_ins_a: assert property (trg && tw[`MPS_F_INS] |=> o_cmd.start && o_cmd.slot == $past(i_discrete_input)
      && o_cmd.abort == $past(r.fsm == mps_pkg::MPS_RUN && !r.done_seen) && r.fresh)
      else $error("external interrupt not immediate");
   ext_hold_a: assert property (trg && !tw[`MPS_F_INS] && r.fsm == mps_pkg::MPS_RUN && !r.done_seen
      |=> r.pend_v && r.pend == $past(i_discrete_input))
      else $error("trigger not held pending");
   lock_rej_a: assert property (i_psel && i_penable && r.pready && i_pwrite && !r.pslverr && r.servo_on_input
      && i_paddr == `MPS_A_PVAL && r.attr[0][`MPS_AT_LCK] |=> r.rej && $stable(r.par_st[0]))
      else $error("locked parameter changed");
   restart_a: assert property (!i_power_cycle && r.attr[0][`MPS_AT_RST] |=> $stable(r.par_ap[0]))
      else $error("restart parameter applied early");
   volatile_a: assert property (i_power_cycle && r.attr[0][`MPS_AT_VOL] |=> r.par_ap[0] == 32'h0)
      else $error("volatile parameter survived");
   one_prog_a: assert property (o_cmd.start |-> o_active && o_cmd.slot != 6'h00 && r.cur == o_cmd.slot)
      else $error("launch without single owner");

   overlap_link_flag_c:  cover property (o_cmd.start && o_cmd.overlap);
   abort_c: cover property (o_cmd.start && o_cmd.abort);
   wait_c:  cover property (r.fsm == mps_pkg::MPS_WAIT ##[1:20] o_cmd.start);
endmodule // mps_top

// [tb/mps_engine_model.sv]
// motion engine model that answers sequencer launches with decel and done pulses
`timescale 1ns/1ps
module mps_engine_model (
   input  wire logic              i_clk,
   input  wire logic              i_sys_rst,
   input  wire mps_pkg::mps_cmd_s i_cmd,
   input  wire logic [15:0]       i_len,
   input  wire logic [15:0]       i_dec_at,
   output logic                   o_mot_done,
   output logic                   o_mot_decel
);
   logic [15:0] cnt_reg;
   // a new launch restarts the move, so an aborted move is simply dropped
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
         cnt_reg <= 16'h0000;
      else if (i_cmd.start)
         cnt_reg <= i_len;
      else if (cnt_reg != 16'h0000)
         cnt_reg <= cnt_reg - 16'h0001;
   end
   // len of zero never finishes; len must exceed 2 so nothing lands right after a launch
   assign o_mot_done  = (cnt_reg == 16'h0001);
   assign o_mot_decel = (i_dec_at != 16'h0000) && (cnt_reg == i_dec_at);
endmodule // mps_engine_model

// [tb/mps_bench.sv]
// self-checking bench for the motion program sequencer
`timescale 1ns/1ps
`include "mps_regs.svh"
module mps_bench;
   localparam int TICK = 4;
   logic              clk, rst, psel, penable, pwrite, trig, servo_in, pcyc;
   logic [11:0]       paddr;
   logic [31:0]       pwdata, prdata, rd;
   logic [5:0]        din;
   logic              pready, pslverr, err, done, decel, active, servo_on;
   logic [15:0]       len, dec_at;
   mps_pkg::mps_cmd_s cmd, seen;
   int                errors, samples_checked, w;
   int                cyc_cnt = 0;

   mps_top #(.TICK_CYC(TICK)) dut (.i_clk(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_discrete_input(din), .i_trigger(trig), .i_servo_on_input(servo_in),
      .i_power_cycle(pcyc), .i_mot_done(done), .i_mot_decel(decel), .o_cmd(cmd), .o_active(active),
      .o_servo_on(servo_on));
   mps_engine_model engine (.i_clk(clk), .i_sys_rst(rst), .i_cmd(cmd), .i_len(len), .i_dec_at(dec_at),
      .o_mot_done(done), .o_mot_decel(decel));

   // ==========================================
   // clock and hang guard
   always #2 clk = ~clk;
   always @(posedge clk)
   begin
      cyc_cnt <= cyc_cnt + 1;
      if (cyc_cnt == 5000)
      begin
         errors++;
         summarize();
      end
   end

   // ==========================================
   // tasks
   task automatic summarize;
      if (errors == 0 && samples_checked > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e)
      begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask

   // apb master: request held until pready is sampled, one idle edge after each transfer
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge clk);
      penable <= 1'b1;
      // no local limit: only the bench timeout ends a stuck wait
      do
         @(posedge clk);
      while (pready !== 1'b1);
      rd  = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask

   task automatic fire(input logic [5:0] s);
      din  <= s;
      trig <= 1'b1;
      @(posedge clk);
      trig <= 1'b0;
   endtask

   // waits for the next launch, counting edges in w
   task automatic launch(input string nm, input logic ov, input logic [5:0] s);
      w = 0;
      do
      begin
         @(posedge clk);
         w++;
      end
      while (cmd.start !== 1'b1 && w < 2000);
      seen = cmd;
      chk(nm, {24'h0, 1'b1, ov, s}, {24'h0, seen.start, seen.overlap, seen.slot});
   endtask

   function automatic logic [31:0] pw(input logic [2:0] t, input logic [2:0] fl, input logic [3:0] d);
      logic [31:0] v;
      v = 32'h0;
      v[`MPS_F_TYPE] = t;
      v[`MPS_F_INS]  = fl[0];
      v[`MPS_F_OVERLAP_LINK_FLAG] = fl[1];
      v[`MPS_F_AUTO] = fl[2];
      v[`MPS_F_DLY]  = d;
      return v;
   endfunction

   function automatic logic [11:0] ps(input int s);
      return `MPS_A_PROG + 12'(4 * s);
   endfunction

   // ==========================================
   // main sequence
   initial
   begin
      {clk, rst, psel, penable, pwrite, trig, servo_in, pcyc} = 8'h42;
      {paddr, pwdata, din, len, dec_at} = '0;
      {errors, samples_checked} = '0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rdc("ctrl reset", `MPS_A_CTRL, 32'h1);
      rdc("stat reset", `MPS_A_STAT, 32'h0);
      apb(1'b0, 12'h008, 32'h0);
      chk("unmapped err", 32'h1, {31'h0, err});
      apb(1'b0, 12'h002, 32'h0);
      chk("misaligned err", 32'h1, {31'h0, err});
      apb(1'b1, ps(0), 32'h7);
      rdc("slot zero", ps(0), 32'h0);
      // every control type; bits above the word are dropped
      for (int t = 0; t < 5; t++)
      begin
         apb(1'b1, ps(50 + t), 32'hfff0_0000 | pw(3'(t), 3'h0, 4'(t)) | {14'h0, 6'(t + 1), 12'h0});
         rdc("slot type", ps(50 + t), pw(3'(t), 3'h0, 4'(t)) | {14'h0, 6'(t + 1), 12'h0});
      end
      apb(1'b1, ps(63), pw(3'h4, 3'h7, 4'hf));
      rdc("slot last", ps(63), pw(3'h4, 3'h7, 4'hf));
      apb(1'b1, `MPS_A_DLY + 12'h004, 32'h3);
      // sequential link: delay counted from completion
      apb(1'b1, ps(5), pw(3'h1, 3'b100, 4'h1));
      apb(1'b1, ps(6), pw(3'h1, 3'b000, 4'h0));
      len <= 16'd20;
      fire(6'd5);
      launch("seq first", 1'b0, 6'd5);
      launch("seq next", 1'b0, 6'd6);
      chk("seq gap", 32'h1, 32'(w >= 32 && w <= 40));
      repeat (25) @(posedge clk);
      // path jump continues at its target slot, not at the next one
      apb(1'b1, ps(30), pw(3'h2, 3'b100, 4'h0) | 32'h0002_1000);
      fire(6'd30);
      launch("jump first", 1'b0, 6'd30);
      launch("jump next", 1'b0, 6'd33);
      repeat (25) @(posedge clk);
      // overlap only between two positioning programs, delay left at zero
      dec_at <= 16'd8;
      for (int k = 0; k < 2; k++)
      begin
         apb(1'b1, ps(10 + 2 * k), pw(3'(1 - k), 3'b110, 4'h0));
         apb(1'b1, ps(11 + 2 * k), pw(3'h1, 3'b000, 4'h0));
         fire(6'(10 + 2 * k));
         launch("ovl first", 1'b0, 6'(10 + 2 * k));
         launch("ovl next", 1'(1 - k), 6'(11 + 2 * k));
         chk("ovl early", 32'(k == 0), 32'(w < 20));
         repeat (25) @(posedge clk);
      end
      dec_at <= 16'd0;
      // internal interrupt: delay from start of previous, aborting it
      apb(1'b1, ps(20), pw(3'h1, 3'b100, 4'h1));
      apb(1'b1, ps(21), pw(3'h1, 3'b001, 4'h0));
      apb(1'b1, ps(40), pw(3'h1, 3'b001, 4'h0));
      len <= 16'd200;
      fire(6'd20);
      launch("ins first", 1'b0, 6'd20);
      launch("ins next", 1'b0, 6'd21);
      chk("ins abort", 32'h1, {31'h0, seen.abort});
      chk("ins gap", 32'h1, 32'(w >= 12 && w <= 18));
      // external interrupt replaces the running move at once
      len <= 16'd40;
      fire(6'd40);
      launch("ext ins", 1'b0, 6'd40);
      chk("ext ins now", 32'h1, 32'(w));
      chk("ext abort", 32'h1, {31'h0, seen.abort});
      chk("active run", 32'h1, {31'h0, active});
      // plain triggers wait; the newer one replaces the older
      fire(6'd41);
      @(posedge clk);
      fire(6'd42);
      rdc("stat pending", `MPS_A_STAT, 32'h2a01_2801);
      launch("pend start", 1'b0, 6'd42);
      chk("pend waited", 32'h1, 32'(w >= 20));
      repeat (45) @(posedge clk);
      chk("active idle", 32'h0, {31'h0, active});
      // parameter attributes: locked, restart, volatile, plain
      apb(1'b1, `MPS_A_PATR, 32'h4);
      apb(1'b1, `MPS_A_PATR + 12'h004, 32'h2);
      apb(1'b1, `MPS_A_PATR + 12'h008, 32'h1);
      apb(1'b1, `MPS_A_PVAL, 32'h55);
      rdc("locked", `MPS_A_PVAL, 32'h0);
      apb(1'b0, `MPS_A_STAT, 32'h0);
      chk("reject", 32'h1, {31'h0, rd[31]});
      apb(1'b1, `MPS_A_CTRL, 32'h0);
      @(posedge clk);
      chk("servo off", 32'h0, {31'h0, servo_on});
      apb(1'b1, `MPS_A_PVAL, 32'h55);
      rdc("unlocked", `MPS_A_PVAL, 32'h55);
      apb(1'b1, `MPS_A_CTRL, 32'h1);
      chk("servo on", 32'h1, {31'h0, servo_on});
      apb(1'b1, `MPS_A_STAT, 32'h0);
      apb(1'b0, `MPS_A_STAT, 32'h0);
      chk("reject clear", 32'h0, {31'h0, rd[31]});
      apb(1'b1, `MPS_A_PVAL + 12'h004, 32'h77);
      rdc("restart before", `MPS_A_PVAL + 12'h004, 32'h0);
      apb(1'b1, `MPS_A_PVAL + 12'h008, 32'h33);
      rdc("volatile before", `MPS_A_PVAL + 12'h008, 32'h33);
      apb(1'b1, `MPS_A_PVAL + 12'h00c, 32'h11);
      pcyc <= 1'b1;
      @(posedge clk);
      pcyc <= 1'b0;
      @(posedge clk);
      rdc("restart after", `MPS_A_PVAL + 12'h004, 32'h77);
      rdc("volatile after", `MPS_A_PVAL + 12'h008, 32'h0);
      rdc("plain after", `MPS_A_PVAL + 12'h00c, 32'h11);
      summarize();
   end
endmodule // mps_bench
